/* inc/scg_pkg.sv */
// constants, offsets and field layout of the sleep clock gating block
package scg_pkg;

  // register bus geometry
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;

  typedef logic [ADDR_W-1:0] scg_addr_t;
  typedef logic [DATA_W-1:0] scg_word_t;

  // register byte offsets from the system control base
  localparam scg_addr_t SLEEP_EN_OFS = 12'h114;
  localparam scg_addr_t RUN_CFG_OFS = 12'h200;
  localparam scg_addr_t IRQ_STATUS_OFS = 12'h204;
  localparam scg_addr_t IRQ_CLEAR_OFS = 12'h208;
  localparam scg_addr_t IRQ_ENABLE_OFS = 12'h20c;
  localparam scg_addr_t FAULT_UNITS_OFS = 12'h210;
  localparam scg_addr_t FAULT_META_OFS = 12'h214;

  // bit position of each gated unit in the enable word
  localparam int unsigned BIT_ASYNC_SERIAL_ZERO = 0;
  localparam int unsigned BIT_ASYNC_SERIAL_ONE = 1;
  localparam int unsigned BIT_SYNC_SERIAL_ZERO = 4;
  localparam int unsigned BIT_TWO_WIRE_ZERO = 12;
  localparam int unsigned BIT_GP_COUNTER_ZERO = 16;
  localparam int unsigned BIT_GP_COUNTER_ONE = 17;
  localparam int unsigned BIT_GP_COUNTER_TWO = 18;
  localparam int unsigned BIT_COMPARATOR_ZERO = 24;
  localparam int unsigned BIT_COMPARATOR_ONE = 25;
  localparam int unsigned BIT_COMPARATOR_TWO = 26;

  // writable bits: 26:24, 18:16, 12, 4, 1:0; all others read as zero
  localparam scg_word_t GATE_MASK = 32'h0707_1013;
  localparam scg_word_t SLEEP_EN_RESET = 32'h0000_0000;

  // own run configuration: only the automatic gating select bit
  localparam int unsigned AUTO_GATE_BIT = 0;
  localparam scg_word_t RUN_CFG_MASK = 32'h0000_0001;
  localparam scg_word_t RUN_CFG_RESET = 32'h0000_0000;

  // fault bookkeeping layout
  localparam int unsigned FAULT_WR_BIT = 31;
  localparam int unsigned FAULT_CNT_W = 16;
  localparam logic [FAULT_CNT_W-1:0] FAULT_CNT_MAX = 16'hffff;
  localparam logic [FAULT_CNT_W-1:0] FAULT_CNT_ONE = 16'h0001;

  localparam scg_word_t WORD_ZERO = 32'h0000_0000;

endpackage : scg_pkg

/* inc/scg_irq_if.sv */
// interrupt signals between the register core and the interrupt controller
`timescale 1ns/100ps
interface scg_irq_if;
  import scg_pkg::*;

  scg_word_t events; // one-cycle fault events, enable layout
  scg_word_t wdata; // software write data
  logic clear_wr; // write to the clear register
  logic enable_wr; // write to the enable register
  scg_word_t status; // sticky status bits
  scg_word_t enable; // interrupt enable bits
  logic irq; // level interrupt

  // controller side
  modport ctrl (
    input events, wdata, clear_wr, enable_wr,
    output status, enable, irq
  );

  // event source side
  modport src (
    output events, wdata, clear_wr, enable_wr,
    input status, enable, irq
  );

endinterface : scg_irq_if

/* core/scg_unit_gate.sv */
// clock enable flop and access check for one gated unit
`timescale 1ns/100ps
module scg_unit_gate (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic gate_sel_i,
  input wire logic access_i,
  output logic clk_en_o,
  output logic blocked_o
);

  // registered enable, so the unit sees a glitch-free gate
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // unit starts unclocked
      clk_en_o <= 1'b0;
    end
    else
    begin
      clk_en_o <= gate_sel_i;
    end
  end

  // an access to an unclocked unit cannot complete
  assign blocked_o = access_i & ~clk_en_o;

endmodule : scg_unit_gate

/* core/scg_irq_ctrl.sv */
// sticky fault status, enable mask and level interrupt
`timescale 1ns/100ps
module scg_irq_ctrl #(
  parameter scg_pkg::scg_word_t EVENT_MASK = scg_pkg::GATE_MASK
) (
  input wire logic clk_i,
  input wire logic rst_i,
  scg_irq_if.ctrl irq_bus
);
  import scg_pkg::*;

  scg_word_t next_status; // status after set and clear
  scg_word_t next_enable; // enable after a write

  // a new event wins over a clear in the same cycle
  always_comb
  begin
    next_status = irq_bus.status;
    if (irq_bus.clear_wr)
    begin
      next_status = next_status & ~irq_bus.wdata;
    end
    next_status = (next_status | irq_bus.events) & EVENT_MASK;
  end

  // enable mask keeps only implemented positions
  always_comb
  begin
    next_enable = irq_bus.enable;
    if (irq_bus.enable_wr)
    begin
      next_enable = irq_bus.wdata & EVENT_MASK;
    end
  end

  // status, mask and interrupt level all update together
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_bus.status <= WORD_ZERO;
      irq_bus.enable <= WORD_ZERO;
      irq_bus.irq <= 1'b0;
    end
    else
    begin
      irq_bus.status <= next_status;
      irq_bus.enable <= next_enable;
      irq_bus.irq <= |(next_status & next_enable);
    end
  end

endmodule : scg_irq_ctrl

/* core/scg_sleep_gate.sv */
// sleep mode unit clock enable register with gating and bus fault logic
//
// Summary of operation
// [RQ1] enable bit 18 gates counter two
// [RQ2] enable bit 17 gates counter one
// [RQ3] enable bit 16 gates counter zero
// [RQ4] enable bit 12 gates two-wire unit zero
// [RQ5] enable bit 4 gates sync serial zero
// [RQ6] enable bit 1 gates async serial one
// [RQ7] enable bit 0 gates async serial zero
// [RQ8] access to unclocked unit gives bus fault
// [RQ9] unused bits read zero, ignore writes
// [RQ10] bits 26:24 gate comparators two to zero
// [RQ11] all enables zero after reset
// [RQ12] sleep enables act only with auto gating
// [RQ13] register decoded at offset 0x114
`timescale 1ns/100ps
module scg_sleep_gate (
  input wire logic clk_i,
  input wire logic rst_i,
  // software register port
  input wire scg_pkg::scg_addr_t reg_addr_i,
  input wire scg_pkg::scg_word_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output scg_pkg::scg_word_t reg_rdata_o,
  // power state and run-mode enables from the system controller
  input wire logic sleep_i,
  input wire scg_pkg::scg_word_t run_clk_en_i,
  // peripheral access observed on the processor bus
  input wire scg_pkg::scg_word_t periph_acc_i,
  input wire logic periph_wr_i,
  // gated clock enables and access answers
  output scg_pkg::scg_word_t unit_clk_en_o,
  output logic bus_fault_o,
  output logic access_ok_o,
  output logic irq_o
);
  import scg_pkg::*;

  // software-visible state
  scg_word_t sleep_unit_clock_enables; // sleep gate per unit
  scg_word_t run_clock_config; // holds the auto gating select
  scg_word_t fault_units; // units hit by the latest fault
  logic fault_last_wr; // latest fault was a write
  logic [FAULT_CNT_W-1:0] fault_count; // saturating fault count

  // derived signals
  scg_word_t next_gate_sel; // enable chosen for each unit
  scg_word_t blocked; // accesses to unclocked units
  scg_word_t granted; // accesses to clocked units
  scg_word_t next_rdata; // read mux result
  logic auto_gating_select; // sleep enables take effect
  logic sleep_gating; // currently using sleep enables

  // register write decodes
  logic wr_sleep_en;
  logic wr_run_cfg;
  logic wr_irq_clear;
  logic wr_irq_enable;
  logic wr_fault_meta;

  // interrupt plumbing
  scg_irq_if irq_bus ();

  // address decode for software writes
  always_comb
  begin
    // offset 0x114 decode
    // [RQ13] sleep register decode
    wr_sleep_en = reg_wr_i && (reg_addr_i == SLEEP_EN_OFS);
    // run configuration, auto gating select only
    wr_run_cfg = reg_wr_i && (reg_addr_i == RUN_CFG_OFS);
    // interrupt clear, write one to clear
    wr_irq_clear = reg_wr_i && (reg_addr_i == IRQ_CLEAR_OFS);
    // interrupt enable mask
    wr_irq_enable = reg_wr_i && (reg_addr_i == IRQ_ENABLE_OFS);
    // any write here empties the fault count, or sets it to one if a fault lands in the same cycle
    wr_fault_meta = reg_wr_i && (reg_addr_i == FAULT_META_OFS);
    // writes to read-only or unmapped offsets decode to nothing
  end

  // sleep enable register; reserved positions are never stored
  // storing only the mask keeps the read path and the gates from ever
  // seeing a reserved bit, whatever software writes back
  // a read-modify-write by software therefore stays harmless
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // [RQ11] enables clear at reset
      sleep_unit_clock_enables <= SLEEP_EN_RESET;
    end
    else if (wr_sleep_en)
    begin
      // [RQ9] reserved bits masked off
      sleep_unit_clock_enables <= reg_wdata_i & GATE_MASK;
    end
  end

  // run configuration register with the gating select
  // limitation: the rest of the run clock configuration lives outside,
  // only the automatic gating select is held here
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // auto gating off after reset
      run_clock_config <= RUN_CFG_RESET;
    end
    else if (wr_run_cfg)
    begin
      // only the select bit is kept
      run_clock_config <= reg_wdata_i & RUN_CFG_MASK;
    end
  end

  // select bit that lets the sleep set take over
  assign auto_gating_select = run_clock_config[AUTO_GATE_BIT];

  // choose which enable set drives the unit clocks
  // the choice is sampled into the gate flops, so a change of sleep_i
  // reaches the unit enables one clock later; the delay buys a clean
  // enable with no decode glitch reaching a unit
  always_comb
  begin
    // [RQ12] auto gating selects sleep set
    sleep_gating = sleep_i & auto_gating_select;
    if (sleep_gating)
    begin
      // sleep with auto gating: the sleep register decides
      next_gate_sel = sleep_unit_clock_enables;
    end
    else
    begin
      // otherwise the run-mode set stays in force
      next_gate_sel = run_clk_en_i & GATE_MASK;
    end
  end

  // one gate per enable position; reserved positions see a zero select,
  // so their enables stay low and any access there faults
  // the reserved flops reduce to constants; the uniform loop is kept
  // so that a future unit only needs a new bit in the mask
  for (genvar g = 0; g < DATA_W; g++)
  begin : g_unit
    // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5] [RQ6] [RQ7] [RQ10] unit clock gates
    scg_unit_gate u_gate (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .gate_sel_i(next_gate_sel[g] & GATE_MASK[g]),
      .access_i(periph_acc_i[g]),
      .clk_en_o(unit_clk_en_o[g]),
      .blocked_o(blocked[g])
    );
  end

  // accesses that land on a clocked unit
  // used only for the completion answer
  assign granted = periph_acc_i & unit_clk_en_o;

  // answer to peripheral accesses, one cycle after the strobe
  // registered answers cost a cycle of latency but keep the fault
  // output free of decode glitches
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // no answer pending after reset
      bus_fault_o <= 1'b0;
      access_ok_o <= 1'b0;
    end
    else
    begin
      // [RQ8] fault instead of completion
      bus_fault_o <= |blocked;
      // a fault on any target suppresses the completion
      access_ok_o <= (|granted) & ~(|blocked);
    end
  end

  // capture which units faulted and how
  // only the latest fault is kept; an older one is overwritten
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // nothing has faulted yet
      fault_units <= WORD_ZERO;
      fault_last_wr <= 1'b0;
    end
    else if (|blocked)
    begin
      // [RQ8] record the faulting access
      fault_units <= blocked;
      fault_last_wr <= periph_wr_i;
    end
  end

  // fault counter: software write clears, a fault in the same cycle
  // still counts so that no event is lost; saturates rather than wraps
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // count starts empty
      fault_count <= '0;
    end
    else if (wr_fault_meta)
    begin
      // software clear, a fault in the same cycle wins one count
      fault_count <= (|blocked) ? FAULT_CNT_ONE : '0;
    end
    else if ((|blocked) && (fault_count != FAULT_CNT_MAX))
    begin
      // one more fault, held at the top
      fault_count <= fault_count + FAULT_CNT_ONE;
    end
  end

  // interrupt controller hookup: faults are the events
  // a blocked access is the event of its own unit position
  assign irq_bus.events = blocked;
  // clear and enable writes share the software write data
  assign irq_bus.wdata = reg_wdata_i;
  assign irq_bus.clear_wr = wr_irq_clear;
  assign irq_bus.enable_wr = wr_irq_enable;

  // every position may fault, so the status keeps all 32 bits
  scg_irq_ctrl #(
    .EVENT_MASK(WORD_ZERO | ~WORD_ZERO)
  ) u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .irq_bus(irq_bus.ctrl)
  );

  // interrupt level comes straight from the controller flop
  assign irq_o = irq_bus.irq;

  // read mux; unmapped and write-only offsets read as zero
  always_comb
  begin
    next_rdata = WORD_ZERO;
    unique case (reg_addr_i)
      SLEEP_EN_OFS:
      begin
        // [RQ9] reserved bits read zero
        next_rdata = sleep_unit_clock_enables & GATE_MASK;
      end
      RUN_CFG_OFS:
      begin
        // auto gating select
        next_rdata = run_clock_config;
      end
      IRQ_STATUS_OFS:
      begin
        // sticky fault status
        next_rdata = irq_bus.status;
      end
      IRQ_ENABLE_OFS:
      begin
        // interrupt mask
        next_rdata = irq_bus.enable;
      end
      FAULT_UNITS_OFS:
      begin
        // units hit by the latest fault
        next_rdata = fault_units;
      end
      FAULT_META_OFS:
      begin
        // write flag and saturating count
        next_rdata[FAULT_WR_BIT] = fault_last_wr;
        next_rdata[FAULT_CNT_W-1:0] = fault_count;
      end
      default:
      begin
        // clear register and unmapped space
        next_rdata = WORD_ZERO;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // bus idle after reset
      reg_rdata_o <= WORD_ZERO;
    end
    else if (reg_rd_i)
    begin
      // answer the strobe
      reg_rdata_o <= next_rdata;
    end
    else
    begin
      // zero between reads keeps stale data off the read bus
      reg_rdata_o <= WORD_ZERO;
    end
  end

endmodule : scg_sleep_gate

/* testbench/scg_sleep_gate_props.sv */
// port assertions for the sleep clock gating block
`timescale 1ns/100ps
module scg_sleep_gate_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire scg_pkg::scg_addr_t reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire scg_pkg::scg_word_t reg_rdata_o,
  input wire logic sleep_i,
  input wire scg_pkg::scg_word_t run_clk_en_i,
  input wire scg_pkg::scg_word_t periph_acc_i,
  input wire scg_pkg::scg_word_t unit_clk_en_o,
  input wire logic bus_fault_o,
  input wire logic access_ok_o,
  input wire logic irq_o
);
  import scg_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // an access hits at least one unclocked unit
  wire logic blk = |(periph_acc_i & ~unit_clk_en_o);
  // irq may rise from a fresh fault or a late enable write
  wire logic en_wr = reg_wr_i && (reg_addr_i == IRQ_ENABLE_OFS);
  property p_rst_clr; $fell(rst_i) |-> unit_clk_en_o == WORD_ZERO && !irq_o; endproperty
  a_rst_clr: assert property (p_rst_clr) else $error("enables set after reset");
  property p_resv; (unit_clk_en_o & ~GATE_MASK) == WORD_ZERO; endproperty
  a_resv: assert property (p_resv) else $error("reserved enable driven");
  property p_resv_rd;
    $past(reg_rd_i && reg_addr_i == SLEEP_EN_OFS) |-> (reg_rdata_o & ~GATE_MASK) == WORD_ZERO;
  endproperty
  a_resv_rd: assert property (p_resv_rd) else $error("reserved bit read set");
  property p_fault; $past(blk) |-> bus_fault_o && !access_ok_o; endproperty
  a_fault: assert property (p_fault) else $error("no fault on blocked access");
  property p_ok; $past(|periph_acc_i && !blk) |-> access_ok_o && !bus_fault_o; endproperty
  a_ok: assert property (p_ok) else $error("clocked access not completed");
  property p_quiet; !$past(|periph_acc_i) |-> !bus_fault_o && !access_ok_o; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without access");
  property p_run;
    !$past(rst_i) && !$past(sleep_i) |-> unit_clk_en_o == ($past(run_clk_en_i) & GATE_MASK);
  endproperty
  a_run: assert property (p_run) else $error("awake gates differ");
  property p_irq; $rose(irq_o) |-> bus_fault_o || $past(en_wr) || $past(en_wr, 2); endproperty
  a_irq: assert property (p_irq) else $error("irq rose without cause");
  c_fault: cover property (bus_fault_o);
  c_ok: cover property (access_ok_o);
  c_irq: cover property ($rose(irq_o));
endmodule : scg_sleep_gate_props

/* testbench/scg_periph_model.sv */
// processor side that issues one-cycle accesses to gated units
`timescale 1ns/100ps
module scg_periph_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire scg_pkg::scg_word_t mask_i,
  input wire logic wr_i,
  output scg_pkg::scg_word_t acc_o,
  output logic wr_o
);
  import scg_pkg::*;
  // one access per request; lines fall back to idle zero at once
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !go_i)
    begin
      acc_o <= WORD_ZERO;
      wr_o <= 1'b0;
    end
    else
    begin
      acc_o <= mask_i;
      wr_o <= wr_i;
    end
  end
endmodule : scg_periph_model

/* testbench/scg_sleep_gate_bench.sv */
// self-checking bench for the sleep clock gating block
`timescale 1ns/100ps
module scg_sleep_gate_bench;
  import scg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  scg_addr_t reg_addr_i = 12'h000;
  scg_word_t reg_wdata_i = WORD_ZERO;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic sleep_i = 1'b0;
  scg_word_t run_clk_en_i = WORD_ZERO;
  logic go = 1'b0; // access request to the peer
  logic go_wr = 1'b0;
  scg_word_t go_mask = WORD_ZERO;
  scg_word_t periph_acc_i;
  logic periph_wr_i;
  scg_word_t reg_rdata_o;
  scg_word_t unit_clk_en_o;
  logic bus_fault_o;
  logic access_ok_o;
  logic irq_o;
  int error_cnt = 0;
  int checks = 0;
  // every gated unit position
  int unsigned units [10] = '{BIT_GP_COUNTER_TWO, BIT_GP_COUNTER_ONE, BIT_GP_COUNTER_ZERO,
    BIT_TWO_WIRE_ZERO, BIT_SYNC_SERIAL_ZERO, BIT_ASYNC_SERIAL_ONE, BIT_ASYNC_SERIAL_ZERO,
    BIT_COMPARATOR_TWO, BIT_COMPARATOR_ONE, BIT_COMPARATOR_ZERO};
  scg_sleep_gate dut (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .sleep_i, .run_clk_en_i, .periph_acc_i, .periph_wr_i, .unit_clk_en_o,
    .bus_fault_o, .access_ok_o, .irq_o);
  scg_periph_model peer (.clk_i, .rst_i, .go_i(go), .mask_i(go_mask), .wr_i(go_wr),
    .acc_o(periph_acc_i), .wr_o(periph_wr_i));
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic finish_test;
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic check(input string n, input scg_word_t seen, input scg_word_t exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic wr(input scg_addr_t a, input scg_word_t d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rdc(input scg_addr_t a, input scg_word_t exp);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 check("read data", reg_rdata_o, exp);
  endtask : rdc
  // enables land one edge after their cause
  task automatic gate(input scg_word_t exp);
    @(posedge clk_i);
    #1 check("unit enables", unit_clk_en_o, exp);
  endtask : gate
  // f set: the access must fault, else complete; w marks a write
  task automatic acc(input scg_word_t m, input logic f, input logic w = 1'b1);
    @(posedge clk_i);
    go <= 1'b1;
    go_mask <= m;
    go_wr <= w;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    #1 check("answer", scg_word_t'({access_ok_o, bus_fault_o}), scg_word_t'({!f, f}));
  endtask : acc
  task automatic t_regs;
    rdc(SLEEP_EN_OFS, SLEEP_EN_RESET);
    wr(SLEEP_EN_OFS, 32'hffff_ffff);
    rdc(SLEEP_EN_OFS, GATE_MASK);
    wr(12'h104, WORD_ZERO);
    rdc(SLEEP_EN_OFS, GATE_MASK);
    rdc(12'h118, WORD_ZERO);
  endtask : t_regs
  task automatic t_run;
    @(posedge clk_i);
    run_clk_en_i <= 32'hffff_ffff;
    gate(GATE_MASK);
    acc(32'h0000_0020, 1'b1);
    acc(GATE_MASK, 1'b0);
  endtask : t_run
  // sleep with auto gating: each bit alone drives its unit
  task automatic t_units;
    scg_word_t m;
    wr(RUN_CFG_OFS, 32'hffff_ffff);
    rdc(RUN_CFG_OFS, RUN_CFG_MASK);
    sleep_i <= 1'b1;
    foreach (units[i])
    begin
      m = WORD_ZERO;
      m[units[i]] = 1'b1;
      wr(SLEEP_EN_OFS, m);
      gate(m);
      acc(m, 1'b0);
      acc(GATE_MASK, 1'b1);
    end
    wr(RUN_CFG_OFS, WORD_ZERO);
    gate(GATE_MASK);
  endtask : t_units
  task automatic t_irq;
    @(posedge clk_i);
    sleep_i <= 1'b0;
    run_clk_en_i <= WORD_ZERO;
    wr(IRQ_CLEAR_OFS, 32'hffff_ffff);
    wr(IRQ_ENABLE_OFS, 32'h0001_0000);
    rdc(IRQ_ENABLE_OFS, 32'h0001_0000);
    rdc(IRQ_CLEAR_OFS, WORD_ZERO);
    acc(32'h0001_0000, 1'b1);
    check("irq", scg_word_t'(irq_o), 32'h0000_0001);
    rdc(IRQ_STATUS_OFS, 32'h0001_0000);
    wr(IRQ_CLEAR_OFS, 32'h0001_0000);
    #1 check("irq", scg_word_t'(irq_o), WORD_ZERO);
    wr(IRQ_ENABLE_OFS, WORD_ZERO);
    acc(32'h0001_0000, 1'b1);
    check("irq", scg_word_t'(irq_o), WORD_ZERO);
  endtask : t_irq
  // fault record: latest units, write flag, count cleared by software
  task automatic t_fault;
    wr(FAULT_META_OFS, WORD_ZERO);
    rdc(FAULT_META_OFS, 32'h8000_0000);
    acc(32'h0000_0002, 1'b1);
    acc(32'h0000_0011, 1'b1, 1'b0);
    rdc(FAULT_UNITS_OFS, 32'h0000_0011);
    rdc(FAULT_META_OFS, 32'h0000_0002);
  endtask : t_fault
  task automatic t_rerst;
    @(posedge clk_i);
    rst_i <= 1'b1;
    run_clk_en_i <= 32'hffff_ffff;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 check("unit enables", unit_clk_en_o, WORD_ZERO);
    rdc(SLEEP_EN_OFS, WORD_ZERO);
    rdc(IRQ_STATUS_OFS, WORD_ZERO);
    rdc(FAULT_META_OFS, WORD_ZERO);
  endtask : t_rerst
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_run();
    t_units();
    t_irq();
    t_fault();
    t_rerst();
    finish_test();
  end
  // run needs about 160 cycles
  initial
  begin
    #100us;
    error_cnt++;
    finish_test();
  end
endmodule : scg_sleep_gate_bench
bind scg_sleep_gate scg_sleep_gate_props u_props (.clk_i, .rst_i, .reg_addr_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .sleep_i, .run_clk_en_i, .periph_acc_i, .unit_clk_en_o,
  .bus_fault_o, .access_ok_o, .irq_o);
